//--- hw/rsft_pkg.sv
package rsft_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_GLOBAL_OFFSET = 8'h20;
    localparam logic [7:0] ADDR_CAPTURE_MODE = 8'h40;
    localparam logic [7:0] ADDR_CINT_HIGH = 8'h4e;
    localparam logic [7:0] ADDR_CINT_LOW = 8'h4f;
    localparam logic [7:0] ADDR_VCW_HIGH = 8'h50;
    localparam logic [7:0] ADDR_VCW_LOW = 8'h51;
    localparam logic [7:0] ADDR_VRD_HIGH = 8'h52;
    localparam logic [7:0] ADDR_VRD_LOW = 8'h53;
    localparam logic [7:0] ADDR_WRD_HIGH = 8'h54;
    localparam logic [7:0] ADDR_WRD_LOW = 8'h55;
    localparam logic [7:0] ADDR_WCW_HIGH = 8'h56;
    localparam logic [7:0] ADDR_WCW_LOW = 8'h57;
    localparam logic [7:0] ADDR_OVERHEAD_FIRST = 8'h58;
    localparam logic [7:0] ADDR_OVERHEAD_SECOND = 8'h59;
    localparam logic [7:0] ADDR_STATUS = 8'h60;
    localparam logic [7:0] ADDR_CLAMP_CONTROL = 8'h64;
    localparam logic [7:0] ADDR_COL_OFFSET_BASE = 8'h80;
    localparam logic [7:0] ADDR_COL_OFFSET_LAST = 8'hbf;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_SINGLE_SHOT_BIT = 0;
    localparam int CINT_UPDATE_BIT = 6;
    localparam int CLAMP_ENABLE_BIT = 0;
    localparam int SM_SIGN_BIT = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] VCW_RESET = 12'h4ff;
    localparam logic [11:0] VRD_RESET = 12'h3ff;
    localparam logic [11:0] WRD_RESET = 12'h3ff;
    localparam logic [11:0] WCW_RESET = 12'h4ff;
    localparam logic [13:0] CINT_RESET = 14'h0100;
    localparam logic [7:0] CLAMP_CONTROL_RESET = 8'h01;

    // ------------------------------------------------------------------
    // Timing counts and saturation limits
    // ------------------------------------------------------------------
    localparam logic [15:0] ROW_FIXED_OVERHEAD = 16'h0013;
    localparam logic [11:0] CLAMP_ROW_MIN_WIDTH = 12'h510;
    localparam logic [11:0] DARK_ROWS_SKIPPED = 12'h003;
    localparam logic [11:0] DARK_ROWS_SAMPLED = 12'h002;
    localparam logic [5:0] OFFSET_SAT_LIMIT = 6'h1f;
    localparam logic [9:0] PIXEL_CODE_MAX = 10'h3ff;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_INTEG = 3'b010,
        ST_READ = 3'b100
    } rsft_phase_type;

    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wr_data;
    } rsft_reg_req_type;

    typedef struct packed {
        logic frame_start;
        logic row_start;
        logic line_valid;
        logic clamp_sample;
        logic integ_active;
        logic [11:0] reset_row;
    } rsft_sync_type;

    typedef struct packed {
        logic valid;
        logic [9:0] code;
    } rsft_pixel_type;

endpackage

//--- hw/rsft_offset_mem.sv
`timescale 1ns/1ps

module rsft_offset_mem #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 6
) (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0] rd_data;
    } rsft_mem_state_type;

    rsft_mem_state_type state_reg;
    rsft_mem_state_type state_next;

    // Entries power up undefined until software writes them; the array has no reset.
    always_comb begin
        state_next = state_reg;
        if (wr_en) begin
            state_next.words[wr_addr] = wr_data;
        end
        state_next.rd_data = state_reg.words[rd_addr];
    end

    always_ff @(posedge ref_clk) begin
        state_reg <= state_next;
    end

    assign rd_data = state_reg.rd_data;

endmodule // rsft_offset_mem

//--- hw/rsft_frame_timing.sv
`timescale 1ns/1ps

// Function
// - Row time is width, overheads plus 19.
// - Integration is count plus one row times.
// - Continuous mode clips integration to frame rows.
// - Single-shot frame stretches to full integration.
// - Continuous frame is row depth plus one.
// - Both clamp rows at least 1296 columns.
// - Window is clipped by the visible frame; rows only in continuous mode.
// - Single-shot integrates fully before readout.
// - Single-shot reads window depth plus one.
// - Clamp reestablished at each frame start.
// - Skip three dark rows, sample two.
// - Clamp control register can disable clamping.
// - 64 column offsets repeat per bank.
// - Column offsets are 6-bit signed magnitude.
// - Global offset added to every column.
// - Offset sum saturates at plus/minus 31.
// - Pixels delivered as 10-bit codes.
// - Integration count adopted on update flag toggle.
// - Single-shot idles until trigger, repeats if high.

module rsft_frame_timing (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire rsft_pkg::rsft_reg_req_type reg_req,
    output logic [7:0] reg_rd_data,
    input wire logic trigger,
    input wire logic [9:0] adc_code,
    output rsft_pkg::rsft_sync_type sync_out,
    output rsft_pkg::rsft_pixel_type pixel_out
);

    typedef struct packed {
        logic [5:0] global_offset;
        logic [7:0] capture_mode;
        logic [13:0] cint_written;
        logic cint_flag_written;
        logic cint_flag_seen;
        logic [13:0] cint_active;
        logic [11:0] vcw;
        logic [11:0] vrd;
        logic [11:0] wrd;
        logic [11:0] wcw;
        logic [7:0] overhead_first;
        logic [7:0] overhead_second;
        logic [7:0] clamp_control;
        logic [7:0] rd_data;
        logic [2:0] trig_sync;
        logic trig_level;
        rsft_pkg::rsft_phase_type phase;
        logic [15:0] cyc;
        logic [13:0] row;
        logic pipe_valid;
        logic [9:0] pipe_code;
        rsft_pkg::rsft_sync_type sync;
        rsft_pkg::rsft_pixel_type pixel;
    } rsft_state_type;

    rsft_state_type state_reg;
    rsft_state_type state_next;

    logic [5:0] col_offset;
    logic mem_wr_en;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic signed [7:0] sm_to_signed(input logic [5:0] sm);
        logic signed [7:0] mag;
        mag = signed'({3'h0, sm[4:0]});
        return sm[rsft_pkg::SM_SIGN_BIT] ? -mag : mag;
    endfunction

    function automatic logic [11:0] min12(input logic [11:0] a, input logic [11:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [11:0] byte_write(input logic [11:0] old, input logic high,
                                               input logic [7:0] data);
        return high ? {data[3:0], old[7:0]} : {old[11:8], data};
    endfunction

    // ------------------------------------------------------------------
    // Derived timing
    // ------------------------------------------------------------------
    logic read_phase;
    logic [11:0] read_row;
    logic dark_clamp_row;
    logic [11:0] row_width;
    logic [15:0] row_len;
    logic row_end;
    logic [13:0] integ_rows;
    logic [13:0] read_rows;
    logic [11:0] win_cols;
    logic [11:0] win_rows;
    logic col_in_window;
    logic signed [7:0] offset_sum;
    logic signed [7:0] offset_sat;
    logic signed [11:0] pixel_sum;

    always_comb begin
        read_phase = (state_reg.phase == rsft_pkg::ST_READ);
        read_row = state_reg.row[11:0];
        dark_clamp_row = read_phase && (read_row >= rsft_pkg::DARK_ROWS_SKIPPED) &&
            (read_row < rsft_pkg::DARK_ROWS_SKIPPED + rsft_pkg::DARK_ROWS_SAMPLED);
        row_width = state_reg.vcw;
        if (dark_clamp_row && state_reg.vcw < rsft_pkg::CLAMP_ROW_MIN_WIDTH) begin
            row_width = rsft_pkg::CLAMP_ROW_MIN_WIDTH;
        end
        row_len = {4'h0, row_width} + {8'h0, state_reg.overhead_first} +
            {8'h0, state_reg.overhead_second} + rsft_pkg::ROW_FIXED_OVERHEAD;
        row_end = (state_reg.cyc >= row_len - 16'h0001);
        if (state_reg.capture_mode[rsft_pkg::MODE_SINGLE_SHOT_BIT]) begin
            integ_rows = state_reg.cint_active;
            read_rows = {2'h0, state_reg.wrd};
        end else begin
            integ_rows = (state_reg.cint_active > {2'h0, state_reg.vrd}) ?
                {2'h0, state_reg.vrd} : state_reg.cint_active;
            read_rows = {2'h0, state_reg.vrd};
        end
        win_cols = min12(state_reg.wcw, state_reg.vcw);
        win_rows = min12(state_reg.wrd, state_reg.vrd);
        col_in_window = read_phase && (state_reg.cyc <= {4'h0, win_cols}) &&
            (state_reg.capture_mode[rsft_pkg::MODE_SINGLE_SHOT_BIT] || read_row <= win_rows);
        offset_sum = sm_to_signed(state_reg.global_offset) + sm_to_signed(col_offset);
        offset_sat = offset_sum;
        if (offset_sum > 8'sd31) begin
            offset_sat = signed'({2'h0, rsft_pkg::OFFSET_SAT_LIMIT});
        end else if (offset_sum < -8'sd31) begin
            offset_sat = -signed'({2'h0, rsft_pkg::OFFSET_SAT_LIMIT});
        end
        pixel_sum = signed'({2'h0, state_reg.pipe_code}) + 12'(offset_sat);
    end

    assign mem_wr_en = reg_req.wr_en && (reg_req.addr >= rsft_pkg::ADDR_COL_OFFSET_BASE) &&
        (reg_req.addr <= rsft_pkg::ADDR_COL_OFFSET_LAST);

    rsft_offset_mem #(
        .DEPTH(64),
        .WIDTH(6)
    ) u_offset_mem (
        .ref_clk(ref_clk),
        .wr_en(mem_wr_en),
        .wr_addr(reg_req.addr[5:0]),
        .wr_data(reg_req.wr_data[5:0]),
        .rd_addr(state_reg.cyc[5:0]),
        .rd_data(col_offset)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.sync.frame_start = 1'b0;
        state_next.sync.row_start = 1'b0;

        // Register writes.
        if (reg_req.wr_en) begin
            unique case (reg_req.addr)
                rsft_pkg::ADDR_GLOBAL_OFFSET: state_next.global_offset = reg_req.wr_data[5:0];
                rsft_pkg::ADDR_CAPTURE_MODE: state_next.capture_mode = reg_req.wr_data;
                rsft_pkg::ADDR_CINT_HIGH: begin
                    state_next.cint_written[13:8] = reg_req.wr_data[5:0];
                    state_next.cint_flag_written =
                        reg_req.wr_data[rsft_pkg::CINT_UPDATE_BIT];
                end
                rsft_pkg::ADDR_CINT_LOW: state_next.cint_written[7:0] = reg_req.wr_data;
                rsft_pkg::ADDR_VCW_HIGH,
                rsft_pkg::ADDR_VCW_LOW:
                    state_next.vcw = byte_write(state_reg.vcw, ~reg_req.addr[0],
                        reg_req.wr_data);
                rsft_pkg::ADDR_VRD_HIGH,
                rsft_pkg::ADDR_VRD_LOW:
                    state_next.vrd = byte_write(state_reg.vrd, ~reg_req.addr[0],
                        reg_req.wr_data);
                rsft_pkg::ADDR_WRD_HIGH,
                rsft_pkg::ADDR_WRD_LOW:
                    state_next.wrd = byte_write(state_reg.wrd, ~reg_req.addr[0],
                        reg_req.wr_data);
                rsft_pkg::ADDR_WCW_HIGH,
                rsft_pkg::ADDR_WCW_LOW:
                    state_next.wcw = byte_write(state_reg.wcw, ~reg_req.addr[0],
                        reg_req.wr_data);
                rsft_pkg::ADDR_OVERHEAD_FIRST: state_next.overhead_first = reg_req.wr_data;
                rsft_pkg::ADDR_OVERHEAD_SECOND: state_next.overhead_second = reg_req.wr_data;
                rsft_pkg::ADDR_CLAMP_CONTROL: state_next.clamp_control = reg_req.wr_data;
                default: begin
                end
            endcase
        end

        // Register reads return one cycle later.
        unique case (reg_req.addr)
            rsft_pkg::ADDR_GLOBAL_OFFSET: state_next.rd_data = {2'h0, state_reg.global_offset};
            rsft_pkg::ADDR_CAPTURE_MODE: state_next.rd_data = state_reg.capture_mode;
            rsft_pkg::ADDR_CINT_HIGH:
                state_next.rd_data = {1'b0, state_reg.cint_flag_written, state_reg.cint_active[13:8]};
            rsft_pkg::ADDR_CINT_LOW: state_next.rd_data = state_reg.cint_active[7:0];
            rsft_pkg::ADDR_VCW_HIGH: state_next.rd_data = {4'h0, state_reg.vcw[11:8]};
            rsft_pkg::ADDR_VCW_LOW: state_next.rd_data = state_reg.vcw[7:0];
            rsft_pkg::ADDR_VRD_HIGH: state_next.rd_data = {4'h0, state_reg.vrd[11:8]};
            rsft_pkg::ADDR_VRD_LOW: state_next.rd_data = state_reg.vrd[7:0];
            rsft_pkg::ADDR_WRD_HIGH: state_next.rd_data = {4'h0, state_reg.wrd[11:8]};
            rsft_pkg::ADDR_WRD_LOW: state_next.rd_data = state_reg.wrd[7:0];
            rsft_pkg::ADDR_WCW_HIGH: state_next.rd_data = {4'h0, state_reg.wcw[11:8]};
            rsft_pkg::ADDR_WCW_LOW: state_next.rd_data = state_reg.wcw[7:0];
            rsft_pkg::ADDR_OVERHEAD_FIRST: state_next.rd_data = state_reg.overhead_first;
            rsft_pkg::ADDR_OVERHEAD_SECOND: state_next.rd_data = state_reg.overhead_second;
            rsft_pkg::ADDR_STATUS:
                state_next.rd_data = {4'h0, state_reg.sync.clamp_sample, state_reg.phase};
            rsft_pkg::ADDR_CLAMP_CONTROL: state_next.rd_data = state_reg.clamp_control;
            default: state_next.rd_data = 8'h00;
        endcase

        // Trigger pin: three stages, level changes once the last two agree.
        state_next.trig_sync = {state_reg.trig_sync[1:0], trigger};
        if (state_reg.trig_sync[2] == state_reg.trig_sync[1]) begin
            state_next.trig_level = state_reg.trig_sync[2];
        end

        // Row and frame sequencing.
        if (state_reg.phase != rsft_pkg::ST_IDLE) begin
            state_next.cyc = row_end ? 16'h0000 : state_reg.cyc + 16'h0001;
        end
        unique case (state_reg.phase)
            rsft_pkg::ST_IDLE: begin
                if (!state_reg.capture_mode[rsft_pkg::MODE_SINGLE_SHOT_BIT] ||
                    state_reg.trig_level) begin
                    state_next.phase = state_reg.capture_mode[rsft_pkg::MODE_SINGLE_SHOT_BIT] ?
                        rsft_pkg::ST_INTEG : rsft_pkg::ST_READ;
                    state_next.cyc = 16'h0000;
                    state_next.row = 14'h0000;
                    state_next.sync.frame_start = 1'b1;
                    state_next.sync.row_start = 1'b1;
                end
            end
            rsft_pkg::ST_INTEG: begin
                if (row_end) begin
                    state_next.row = state_reg.row + 14'h0001;
                    state_next.sync.row_start = 1'b1;
                    if (state_reg.row == integ_rows) begin
                        state_next.phase = rsft_pkg::ST_READ;
                        state_next.row = 14'h0000;
                    end
                end
            end
            rsft_pkg::ST_READ: begin
                if (row_end) begin
                    state_next.row = state_reg.row + 14'h0001;
                    state_next.sync.row_start = 1'b1;
                    if (state_reg.row >= read_rows) begin
                        state_next.row = 14'h0000;
                        state_next.sync.frame_start = 1'b1;
                        if (state_reg.capture_mode[rsft_pkg::MODE_SINGLE_SHOT_BIT]) begin
                            // Host trigger level decides whether another frame follows.
                            state_next.phase = state_reg.trig_level ?
                                rsft_pkg::ST_INTEG : rsft_pkg::ST_IDLE;
                            state_next.sync.frame_start = state_reg.trig_level;
                            state_next.sync.row_start = state_reg.trig_level;
                        end
                    end
                end
            end
            default: begin
                state_next.phase = rsft_pkg::ST_IDLE;
                state_next.row = 14'h0000;
            end
        endcase

        // A new integration count takes effect only at a frame boundary.
        if (state_next.sync.frame_start &&
            state_reg.cint_flag_written != state_reg.cint_flag_seen) begin
            state_next.cint_active = state_reg.cint_written;
            state_next.cint_flag_seen = state_reg.cint_flag_written;
        end

        // Sync outputs.
        state_next.sync.line_valid = col_in_window;
        state_next.sync.clamp_sample = dark_clamp_row &&
            state_reg.clamp_control[rsft_pkg::CLAMP_ENABLE_BIT];
        state_next.sync.integ_active = (state_reg.phase == rsft_pkg::ST_INTEG) ||
            (read_phase && !state_reg.capture_mode[rsft_pkg::MODE_SINGLE_SHOT_BIT]);
        if (read_phase && !state_reg.capture_mode[rsft_pkg::MODE_SINGLE_SHOT_BIT]) begin
            // Rolling reset pointer leads readout by the clipped integration rows.
            state_next.sync.reset_row = (read_row + integ_rows[11:0] + 12'h001 > state_reg.vrd) ?
                read_row + integ_rows[11:0] - state_reg.vrd :
                read_row + integ_rows[11:0] + 12'h001;
        end else begin
            state_next.sync.reset_row = read_row;
        end

        // Pixel path: offset memory answers one cycle after the column count.
        state_next.pipe_valid = col_in_window;
        state_next.pipe_code = adc_code;
        state_next.pixel.valid = state_reg.pipe_valid;
        if (pixel_sum < 12'sd0) begin
            state_next.pixel.code = 10'h000;
        end else if (pixel_sum > signed'({2'h0, rsft_pkg::PIXEL_CODE_MAX})) begin
            state_next.pixel.code = rsft_pkg::PIXEL_CODE_MAX;
        end else begin
            state_next.pixel.code = pixel_sum[9:0];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.phase <= rsft_pkg::ST_IDLE;
            state_reg.vcw <= rsft_pkg::VCW_RESET;
            state_reg.vrd <= rsft_pkg::VRD_RESET;
            state_reg.wrd <= rsft_pkg::WRD_RESET;
            state_reg.wcw <= rsft_pkg::WCW_RESET;
            state_reg.cint_written <= rsft_pkg::CINT_RESET;
            state_reg.cint_active <= rsft_pkg::CINT_RESET;
            state_reg.clamp_control <= rsft_pkg::CLAMP_CONTROL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rd_data = state_reg.rd_data;
    assign sync_out = state_reg.sync;
    assign pixel_out = state_reg.pixel;

endmodule // rsft_frame_timing

//--- test/rsft_timing_monitor.sv
`timescale 1ns/1ps

module rsft_timing_monitor (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire rsft_pkg::rsft_reg_req_type reg_req,
    input wire logic [7:0] reg_rd_data,
    input wire logic trigger,
    input wire logic [9:0] adc_code,
    input wire rsft_pkg::rsft_sync_type sync_out,
    input wire rsft_pkg::rsft_pixel_type pixel_out
);
    logic mode_reg;
    logic settled_reg;
    logic clamp_en_reg;
    logic [3:0] off_cnt_reg;
    logic [7:0] trig_hist_reg;

    // ----------------------------------------------------------------
    // Shadows of the mode and clamp writes, and a short trigger history.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mode_reg <= 1'b0;
            settled_reg <= 1'b0;
            clamp_en_reg <= 1'b1;
            off_cnt_reg <= 4'h0;
            trig_hist_reg <= 8'h00;
        end else begin
            trig_hist_reg <= {trig_hist_reg[6:0], trigger};
            if (reg_req.wr_en && reg_req.addr == rsft_pkg::ADDR_CAPTURE_MODE) begin
                mode_reg <= reg_req.wr_data[0];
                settled_reg <= 1'b0;
            end else if (sync_out.frame_start) begin
                settled_reg <= 1'b1;
            end
            if (reg_req.wr_en && reg_req.addr == rsft_pkg::ADDR_CLAMP_CONTROL) begin
                clamp_en_reg <= reg_req.wr_data[0];
                off_cnt_reg <= 4'h0;
            end else if (off_cnt_reg != 4'hf) begin
                off_cnt_reg <= off_cnt_reg + 4'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_clamp_wr_held;
        reg_req.wr_en && reg_req.addr == 8'h64 ##1 reg_req.addr == 8'h64;
    endsequence

    a_row_pulse: assert property (
        sync_out.row_start |=> !sync_out.row_start [*8]) else $error("row start too close");
    a_frame_pulse: assert property (
        sync_out.frame_start |=> !sync_out.frame_start [*8]) else $error("frame start too close");
    a_pixel_lag: assert property (
        pixel_out.valid == $past(sync_out.line_valid)) else $error("pixel valid lag wrong");
    a_clamp_off: assert property (
        !clamp_en_reg && off_cnt_reg == 4'hf |-> !sync_out.clamp_sample)
        else $error("clamp sampled while off");
    a_single_excl: assert property (
        mode_reg && settled_reg |-> !(sync_out.integ_active && sync_out.line_valid))
        else $error("integration overlaps readout");
    a_trig_cause: assert property (
        mode_reg && settled_reg && sync_out.frame_start |-> trig_hist_reg != 8'h00)
        else $error("frame without trigger");
    a_unmapped_zero: assert property (
        !(reg_req.addr inside {8'h20, 8'h40, [8'h4e:8'h59], 8'h60, 8'h64})
        |=> reg_rd_data == 8'h00) else $error("unmapped read not zero");
    a_clamp_readback: assert property (
        s_clamp_wr_held |=> reg_rd_data == $past(reg_req.wr_data, 2))
        else $error("clamp readback wrong");
endmodule // rsft_timing_monitor

bind rsft_frame_timing rsft_timing_monitor u_monitor (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rd_data(reg_rd_data), .trigger(trigger), .adc_code(adc_code),
    .sync_out(sync_out), .pixel_out(pixel_out));

//--- test/rsft_host_model.sv
`timescale 1ns/1ps

module rsft_host_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic trig_req,
    input wire rsft_pkg::rsft_sync_type sync_in,
    input wire rsft_pkg::rsft_pixel_type pix_in,
    output logic trigger,
    output logic [15:0] pix_count,
    output logic [15:0] clamp_count
);
    logic [15:0] pix_acc;
    logic [15:0] clamp_acc;

    // ----------------------------------------------------------------
    // The host paces single-shot frames and tallies each frame.
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        trigger <= trig_req;
        if (!rst_b) begin
            pix_acc <= 16'h0000;
            clamp_acc <= 16'h0000;
            pix_count <= 16'h0000;
            clamp_count <= 16'h0000;
        end else if (sync_in.frame_start) begin
            pix_count <= pix_acc;
            clamp_count <= clamp_acc;
            pix_acc <= 16'(pix_in.valid);
            clamp_acc <= 16'(sync_in.clamp_sample);
        end else begin
            pix_acc <= pix_acc + 16'(pix_in.valid);
            clamp_acc <= clamp_acc + 16'(sync_in.clamp_sample);
        end
    end
endmodule // rsft_host_model

//--- test/tb.sv
`timescale 1ns/1ps

module tb;
    localparam int ROW = 32 + 3 + 5 + 19;
    localparam int CLR = 1296 + 3 + 5 + 19;
    logic ref_clk;
    logic rst_b;
    logic trig_req;
    logic trigger;
    logic [7:0] reg_rd_data;
    logic [9:0] adc_code;
    logic [15:0] pix_count;
    logic [15:0] clamp_count;
    logic [2:0] ev;
    rsft_pkg::rsft_reg_req_type reg_req;
    rsft_pkg::rsft_sync_type sync_out;
    rsft_pkg::rsft_pixel_type pixel_out;
    int fail_count;
    int checks;
    int n;
    int integ;
    int fs;
    logic [15:0] cfg [11] = '{16'h5000, 16'h5120, 16'h5803, 16'h5905, 16'h5200, 16'h5307,
        16'h5400, 16'h5502, 16'h5600, 16'h5764, 16'h8125};
    logic [41:0] otab [3] = '{{6'h14, 6'h0f, 10'h1f4, 10'h213, 10'h203},
        {6'h34, 6'h2f, 10'h1f4, 10'h1d5, 10'h1db}, {6'h34, 6'h2f, 10'h00a, 10'h000, 10'h000}};

    assign ev = {pixel_out.valid, sync_out.row_start, sync_out.frame_start};

    rsft_frame_timing DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rd_data(reg_rd_data), .trigger(trigger), .adc_code(adc_code),
        .sync_out(sync_out), .pixel_out(pixel_out));
    rsft_host_model u_host (.ref_clk(ref_clk), .rst_b(rst_b), .trig_req(trig_req),
        .sync_in(sync_out), .pix_in(pixel_out), .trigger(trigger), .pix_count(pix_count),
        .clamp_count(clamp_count));

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req.addr = a;
        reg_req.wr_data = d;
        reg_req.wr_en = 1'b1;
        tick;
        reg_req.wr_en = 1'b0;
        tick;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_req.addr = a;
        tick;
        chk(32'(reg_rd_data), 32'(e));
    endtask

    task automatic wait_pulse(input int sel);
        n = 0;
        do begin
            tick;
            n++;
        end while (ev[sel] !== 1'b1);
    endtask

    task automatic window(input int len);
        integ = 0;
        fs = 0;
        repeat (len) begin
            integ += int'(sync_out.integ_active === 1'b1);
            tick;
            fs += int'(sync_out.frame_start === 1'b1);
        end
    endtask

    task automatic shot;
        trig_req = 1'b1;
        wait_pulse(0);
        trig_req = 1'b0;
        window(800);
    endtask

    task automatic finish_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        #6000000;
        fail_count++;
        finish_test;
    end

    initial begin
        rst_b = 1'b0;
        trig_req = 1'b0;
        adc_code = 10'h1f4;
        reg_req = '0;
        fail_count = 0;
        checks = 0;
        repeat (6) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        rd(rsft_pkg::ADDR_VCW_HIGH, 8'h04);
        rd(rsft_pkg::ADDR_VCW_LOW, 8'hff);
        rd(rsft_pkg::ADDR_CLAMP_CONTROL, 8'h01);
        rd(8'h10, 8'h00);
        rd(rsft_pkg::ADDR_COL_OFFSET_BASE, 8'h00);
        foreach (cfg[i]) wr(cfg[i][15:8], cfg[i][7:0]);
        $display("test registers done");
        repeat (3) wait_pulse(0);
        chk(n, 6 * ROW + 2 * CLR);
        chk(32'(pix_count), 32'h63);
        chk(32'(clamp_count), 2 * CLR);
        repeat (2) wait_pulse(1);
        chk(n, ROW);
        $display("test continuous timing done");
        for (int i = 0; i < 3; i++) begin
            wr(rsft_pkg::ADDR_GLOBAL_OFFSET, {2'b00, otab[i][41:36]});
            wr(rsft_pkg::ADDR_COL_OFFSET_BASE, {2'b00, otab[i][35:30]});
            adc_code = otab[i][29:20];
            wait_pulse(0);
            wait_pulse(2);
            chk(32'(pixel_out.code), 32'(otab[i][19:10]));
            tick;
            chk(32'(pixel_out.code), 32'(otab[i][9:0]));
        end
        chk(32'(clamp_count), 2 * CLR);
        wr(rsft_pkg::ADDR_CLAMP_CONTROL, 8'h00);
        rd(rsft_pkg::ADDR_CLAMP_CONTROL, 8'h00);
        repeat (2) wait_pulse(0);
        chk(32'(clamp_count), 32'h0);
        $display("test offsets and clamp done");
        wr(rsft_pkg::ADDR_CAPTURE_MODE, 8'h01);
        wr(rsft_pkg::ADDR_CINT_LOW, 8'h02);
        wr(rsft_pkg::ADDR_CINT_HIGH, 8'h40);
        shot;
        chk(integ, 3 * ROW);
        chk(fs, 0);
        rd(rsft_pkg::ADDR_STATUS, 8'h01);
        wr(rsft_pkg::ADDR_CINT_LOW, 8'h05);
        shot;
        chk(integ, 3 * ROW);
        chk(32'(pix_count), 32'h63);
        wr(rsft_pkg::ADDR_CINT_HIGH, 8'h00);
        shot;
        chk(integ, 6 * ROW);
        trig_req = 1'b1;
        wait_pulse(0);
        window(600);
        chk(fs, 1);
        trig_req = 1'b0;
        $display("test single shot done");
        finish_test;
    end
endmodule // tb
